// file: rtl/epo_outputs.sv
// epo_outputs: two digital switching outputs with energy pulse generators.
// assumes measured quantities arrive as signed energy increments with a
// strobe and a quantity index; comparator and external levels are sync.
`timescale 1ns/100ps
module epo_outputs import epo_pkg::*; #(
  parameter int MS_CYCLES = CYCLES_PER_MS, // cycles per millisecond
  parameter int ACC_W = 40, // energy accumulator width
  parameter int VAL_W = 32 // measured increment width
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // parameter access port
  input wire logic [15:0] par_addr,
  input wire logic par_wr,
  input wire logic [15:0] par_wdata,
  input wire logic par_rd,
  output logic [15:0] par_rdata,
  // measured energy increments
  input wire logic meas_strobe,
  input wire logic [15:0] meas_qty,
  input wire logic signed [VAL_W-1:0] meas_value,
  // other output sources
  input wire logic [1:0] cmp_result,
  input wire logic [1:0] ext_value,
  // switching outputs and panel indication
  output logic [1:0] dout,
  output logic [1:0] disp_state
);

  // configuration registers
  logic [15:0] qsel [2]; // measured quantity per channel
  logic [31:0] epp [2]; // signed energy per pulse
  logic [15:0] plen; // pulse length in ms
  logic [15:0] src [2]; // source select per output
  logic [1:0] pulse_on; // pulse generator levels

  // clamp the pulse length into its legal span
  function automatic logic [15:0] clamp_len(input logic [15:0] v);
    if (v < PLEN_MIN_MS) begin
      return PLEN_MIN_MS;
    end else if (v > PLEN_MAX_MS) begin
      return PLEN_MAX_MS;
    end
    return v;
  endfunction

  // address decode
  wire wr_q1 = par_wr && (par_addr == ADDR_QSEL_CH1);
  wire wr_q2 = par_wr && (par_addr == ADDR_QSEL_CH2);
  wire wr_e1h = par_wr && (par_addr == ADDR_EPP_CH1);
  wire wr_e1l = par_wr && (par_addr == ADDR_EPP_CH1 + 16'h0001);
  wire wr_e2h = par_wr && (par_addr == ADDR_EPP_CH2);
  wire wr_e2l = par_wr && (par_addr == ADDR_EPP_CH2 + 16'h0001);
  wire wr_len = par_wr && (par_addr == ADDR_PLEN);
  wire wr_s1 = par_wr && (par_addr == ADDR_SRC_OUT1);
  wire wr_s2 = par_wr && (par_addr == ADDR_SRC_OUT2);
  wire [15:0] len_ms = clamp_len(plen);

  // configuration writes, one word per address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      qsel[0] <= QSEL_RST;
      qsel[1] <= QSEL_RST;
      epp[0] <= EPP_RST;
      epp[1] <= EPP_RST;
      plen <= PLEN_RST;
      src[0] <= SRC_RST;
      src[1] <= SRC_RST;
    end else begin
      if (wr_q1) qsel[0] <= par_wdata;
      if (wr_q2) qsel[1] <= par_wdata;
      if (wr_e1h) epp[0][31:16] <= par_wdata;
      if (wr_e1l) epp[0][15:0] <= par_wdata;
      if (wr_e2h) epp[1][31:16] <= par_wdata;
      if (wr_e2l) epp[1][15:0] <= par_wdata;
      if (wr_len) plen <= par_wdata;
      if (wr_s1) src[0] <= par_wdata;
      if (wr_s2) src[1] <= par_wdata;
    end
  end

  // read mux, unmapped addresses answer zero
  logic [15:0] next_rdata;
  always_comb begin
    case (par_addr)
      ADDR_QSEL_CH1: next_rdata = qsel[0];
      ADDR_QSEL_CH2: next_rdata = qsel[1];
      ADDR_EPP_CH1: next_rdata = epp[0][31:16];
      ADDR_EPP_CH1 + 16'h0001: next_rdata = epp[0][15:0];
      ADDR_EPP_CH2: next_rdata = epp[1][31:16];
      ADDR_EPP_CH2 + 16'h0001: next_rdata = epp[1][15:0];
      ADDR_PLEN: next_rdata = plen;
      ADDR_SRC_OUT1: next_rdata = src[0];
      ADDR_SRC_OUT2: next_rdata = src[1];
      ADDR_STATE_OUT1: next_rdata = {15'h0000, dout[0]};
      ADDR_STATE_OUT2: next_rdata = {15'h0000, dout[1]};
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      par_rdata <= 16'h0000;
    end else if (par_rd) begin
      par_rdata <= next_rdata;
    end
  end

  // shared millisecond tick
  logic [31:0] ms_cnt;
  wire ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ms_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    end
  end

  // one-second panel refresh
  logic [15:0] disp_cnt;
  wire disp_tick = ms_tick && (disp_cnt == 16'(DISPLAY_REFRESH_MS - 1));
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      disp_cnt <= 16'h0000;
      disp_state <= 2'b00;
    end else begin
      if (ms_tick) begin
        disp_cnt <= disp_tick ? 16'h0000 : disp_cnt + 16'h0001;
      end
      if (disp_tick) disp_state <= dout;
    end
  end

  // per-channel pulse generator and output select
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      epo_state_t state; // sequencer state
      logic [ACC_W-1:0] acc; // accrued energy
      logic [15:0] tcnt; // ms elapsed in phase
      wire pulse_mode = (src[ch] == SRC_PULSE);
      wire epp_neg = epp[ch][31];
      wire epp_zero = (epp[ch] == 32'h0000_0000);
      wire [31:0] epp_mag = epp_neg ? (~epp[ch] + 32'h0000_0001) : epp[ch];
      wire val_neg = meas_value[VAL_W-1];
      wire val_zero = (meas_value == '0);
      wire [VAL_W-1:0] val_mag = val_neg ? VAL_W'(-meas_value)
                                         : VAL_W'(meas_value);
      // sign match: positive setting takes positive flow and vice versa
      wire take = meas_strobe && (meas_qty == qsel[ch]) && !epp_zero
                  && !val_zero && (epp_neg == val_neg);
      wire [ACC_W-1:0] inc = take ? ACC_W'(val_mag) : '0;
      wire [ACC_W:0] sum = {1'b0, acc} + {1'b0, inc};
      wire [ACC_W-1:0] acc_sat = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
      wire due = !epp_zero && (acc >= ACC_W'(epp_mag));
      // >= ends the phase even if the length shrank below the count
      wire phase_end = ms_tick && (tcnt >= len_ms - 16'h0001);
      // pulses start on a tick so they last whole milliseconds;
      // a due pulse follows its pause with no idle gap
      wire start = due && ((state == EPO_IDLE && ms_tick)
                   || (state == EPO_PAUSE && phase_end));
      logic [ACC_W-1:0] next_acc;
      assign next_acc = start
                        ? acc_sat - ACC_W'(epp_mag) : acc_sat;

      // sequencer: idle, pulse, pause
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          state <= EPO_IDLE;
          acc <= '0;
          tcnt <= 16'h0000;
        end else if (!pulse_mode) begin
          state <= EPO_IDLE;
          acc <= '0;
          tcnt <= 16'h0000;
        end else begin
          acc <= next_acc;
          if (ms_tick) tcnt <= tcnt + 16'h0001;
          case (state)
            EPO_IDLE: begin
              tcnt <= 16'h0000;
              if (start) state <= EPO_PULSE;
            end
            EPO_PULSE: begin
              if (phase_end) begin
                state <= EPO_PAUSE;
                tcnt <= 16'h0000;
              end
            end
            EPO_PAUSE: begin
              if (phase_end) begin
                state <= start ? EPO_PULSE : EPO_IDLE;
                tcnt <= 16'h0000;
              end
            end
            default: state <= EPO_IDLE;
          endcase
        end
      end
      assign pulse_on[ch] = (state == EPO_PULSE);

      // output source selection
      wire next_out = (src[ch] == SRC_COMPARATOR) ? cmp_result[ch] :
                      (src[ch] == SRC_PULSE) ? pulse_on[ch] :
                      (src[ch] == SRC_EXTERNAL) ? ext_value[ch] : 1'b0;
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          dout[ch] <= 1'b0;
        end else begin
          dout[ch] <= next_out;
        end
      end
    end
  endgenerate

endmodule // epo_outputs

// file: rtl/epo_pkg.sv
// epo_pkg: register map, field values, reset values and timing counts
// shared by the energy pulse digital output block.
// assumes a 16-bit parameter-address port, one word per address.
package epo_pkg;
  // parameter addresses (word addresses)
  localparam logic [15:0] ADDR_QSEL_CH1 = 16'h0064;
  localparam logic [15:0] ADDR_QSEL_CH2 = 16'h0065;
  localparam logic [15:0] ADDR_EPP_CH1 = 16'h0066; // high word, low at +1
  localparam logic [15:0] ADDR_EPP_CH2 = 16'h0068; // high word, low at +1
  localparam logic [15:0] ADDR_PLEN = 16'h006A;
  localparam logic [15:0] ADDR_SRC_OUT1 = 16'h00C8;
  localparam logic [15:0] ADDR_SRC_OUT2 = 16'h00CA;
  localparam logic [15:0] ADDR_STATE_OUT1 = 16'h0260;
  localparam logic [15:0] ADDR_STATE_OUT2 = 16'h0261;
  // source select codes
  localparam logic [15:0] SRC_COMPARATOR = 16'h0000;
  localparam logic [15:0] SRC_PULSE = 16'h0001;
  localparam logic [15:0] SRC_EXTERNAL = 16'h0002;
  // reset values
  localparam logic [15:0] QSEL_RST = 16'h0000;
  localparam logic [31:0] EPP_RST = 32'h0000_0000;
  localparam logic [15:0] PLEN_RST = 16'h001E; // 30 ms
  localparam logic [15:0] SRC_RST = 16'h0000;
  // pulse length limits in ms
  localparam logic [15:0] PLEN_MIN_MS = 16'h000A; // 10 ms
  localparam logic [15:0] PLEN_MAX_MS = 16'h2710; // 10 s
  // timing: clock period and derived millisecond count
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int DISPLAY_REFRESH_MS = 1000;
  // per-channel pulse sequencer states
  typedef enum logic [1:0] {
    EPO_IDLE = 2'b00,
    EPO_PULSE = 2'b01,
    EPO_PAUSE = 2'b10
  } epo_state_t;
endpackage

// file: testbench/epo_outputs_asserts.sv
// checker for the energy pulse outputs, port-level timing relations
// assumes MS_CYCLES equals that of the bound design instance
`timescale 1ns/100ps
module epo_outputs_asserts import epo_pkg::*; #(
  parameter int MS_CYCLES = CYCLES_PER_MS // cycles per ms
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // parameter port
  input wire logic [15:0] par_addr,
  input wire logic par_wr,
  input wire logic [15:0] par_wdata,
  input wire logic par_rd,
  input wire logic [15:0] par_rdata,
  // sources and outputs
  input wire logic [1:0] cmp_result,
  input wire logic [1:0] ext_value,
  input wire logic [1:0] dout,
  input wire logic [1:0] disp_state
);
  localparam int LIM = 10 * MS_CYCLES; // shortest legal run, 10 ms
  localparam int DISP = 1000 * MS_CYCLES - 3; // panel refresh gap
  logic [15:0] s0; // mirrored source of output 1
  logic [15:0] s1; // mirrored source of output 2
  int hc; // high run of output 1
  int lc; // low run of output 1
  int dc; // cycles since panel change
  logic pf; // a pulse ended while in pulse mode
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // mirror source writes and count run lengths
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s0 <= SRC_RST;
      s1 <= SRC_RST;
      hc <= 0;
      lc <= 0;
      dc <= 0;
      pf <= 1'b0;
    end else begin
      if (par_wr && par_addr == ADDR_SRC_OUT1) s0 <= par_wdata;
      if (par_wr && par_addr == ADDR_SRC_OUT2) s1 <= par_wdata;
      hc <= dout[0] ? hc + 1 : 0;
      lc <= dout[0] ? 0 : lc + 1;
      dc <= $changed(disp_state) ? 0 : dc + 1;
      // a fall counts only once the output has followed the generator
      pf <= (s0 == SRC_PULSE) && (pf || ($fell(dout[0])
            && $past(s0) == SRC_PULSE && $past(s0, 2) == SRC_PULSE));
    end
  end
  a_cmp_direct: assert property ($past(nrst, 2)
    && s0 == SRC_COMPARATOR && $past(s0) == SRC_COMPARATOR
    |-> dout[0] == $past(cmp_result[0]))
    else $error("output 1 does not follow its comparator");
  a_ext_direct: assert property ($past(nrst, 2)
    && s1 == SRC_EXTERNAL && $past(s1) == SRC_EXTERNAL
    |-> dout[1] == $past(ext_value[1]))
    else $error("output 2 does not follow its external value");
  a_code_off: assert property ($past(nrst, 2) && s0 > 16'h0002
    && $past(s0) > 16'h0002 |-> !dout[0])
    else $error("output 1 active on an unknown source code");
  a_state_read: assert property (par_rd
    && par_addr == ADDR_STATE_OUT1
    |=> par_rdata == {15'h0000, $past(dout[0])})
    else $error("output 1 state read wrong");
  a_rdata_hold: assert property (!par_rd |=> $stable(par_rdata))
    else $error("read data moved without a read");
  a_pulse_min: assert property (s0 == SRC_PULSE
    && $past(s0) == SRC_PULSE && $past(s0, 2) == SRC_PULSE
    && $fell(dout[0]) |-> hc >= LIM)
    else $error("pulse shorter than the minimum length");
  a_pause_min: assert property (pf && s0 == SRC_PULSE
    && $rose(dout[0]) |-> lc >= LIM)
    else $error("pause shorter than the minimum length");
  a_disp_copy: assert property ($changed(disp_state)
    |-> disp_state == $past(dout) && dc >= DISP)
    else $error("panel indication changed off its refresh");
endmodule // epo_outputs_asserts
bind epo_outputs epo_outputs_asserts #(.MS_CYCLES(MS_CYCLES))
  epo_outputs_asserts_i (
  .ref_clk(ref_clk), .nrst(nrst), .par_addr(par_addr), .par_wr(par_wr),
  .par_wdata(par_wdata), .par_rd(par_rd), .par_rdata(par_rdata),
  .cmp_result(cmp_result), .ext_value(ext_value), .dout(dout),
  .disp_state(disp_state));

// file: testbench/epo_pulse_rx.sv
// pulse receiver model: counts pulses, keeps shortest high and low runs
// assumes one registered switching output, sampled on ref_clk
`timescale 1ns/100ps
module epo_pulse_rx (
  // clock, enable and watched line
  input wire logic ref_clk,
  input wire logic arm,
  input wire logic pin,
  // results
  output int count,
  output int min_hi,
  output int min_lo
);
  int run = 0; // cycles since the last edge
  int n = 0; // rising edges seen while armed
  int mh = 1000000; // shortest whole high run
  int ml = 1000000; // shortest whole low run
  logic last = 1'b0; // pin at the previous edge
  logic seen = 1'b0; // an edge seen since arming, so runs are whole
  assign count = n;
  assign min_hi = mh;
  assign min_lo = ml;
  // measure runs only while armed; the run cut by arming is skipped
  always @(posedge ref_clk) begin
    if (!arm) begin
      run = 0;
      seen = 1'b0;
    end else if (pin !== last) begin
      if (seen && last && run < mh) mh = run;
      if (seen && !last && run < ml) ml = run;
      if (pin) n = n + 1;
      run = 1;
      seen = 1'b1;
    end else begin
      run = run + 1;
    end
    last = pin;
  end
endmodule // epo_pulse_rx

// file: testbench/tb.sv
// top bench: parameter writes, energy increments, model compares
// assumes a 50 MHz ref_clk and a millisecond of 10 cycles
`timescale 1ns/100ps
module tb;
  import epo_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, par_wr = 1'b0, par_rd = 1'b0;
  logic [15:0] par_addr = 16'h0000, par_wdata = 16'h0000, par_rdata;
  logic meas_strobe = 1'b0, arm = 1'b0, ch = 1'b0;
  logic [15:0] meas_qty = 16'h0000;
  logic signed [31:0] meas_value = 32'h00000000;
  logic [1:0] cmp_result = 2'h0, ext_value = 2'h0, dout, disp_state;
  logic [1:0] ex = 2'h0; // expected direct output levels
  logic sw = 1'b0; // output sources swapped
  int mismatches = 0, cmp_count = 0, n0, h0, l0, acc, base;
  localparam int MS = 10; // cycles per millisecond in simulation
  always #10 ref_clk = ~ref_clk;
  epo_outputs #(.MS_CYCLES(MS)) epo_outputs_i (.ref_clk(ref_clk),
    .nrst(nrst), .par_addr(par_addr), .par_wr(par_wr),
    .par_wdata(par_wdata), .par_rd(par_rd), .par_rdata(par_rdata),
    .meas_strobe(meas_strobe), .meas_qty(meas_qty),
    .meas_value(meas_value), .cmp_result(cmp_result),
    .ext_value(ext_value), .dout(dout), .disp_state(disp_state));
  epo_pulse_rx epo_pulse_rx_i (.ref_clk(ref_clk), .arm(arm),
    .pin(dout[ch]), .count(n0), .min_hi(h0), .min_lo(l0));
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    par_addr = a;
    par_wdata = d;
    par_wr = 1'b1;
    @(negedge ref_clk);
    par_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    par_addr = a;
    par_rd = 1'b1;
    @(negedge ref_clk);
    par_rd = 1'b0;
    chk(par_rdata, e);
  endtask
  task automatic meas(input logic [15:0] q, input int v);
    @(negedge ref_clk);
    meas_qty = q;
    meas_value = v;
    meas_strobe = 1'b1;
    @(negedge ref_clk);
    meas_strobe = 1'b0;
  endtask
  // wait for the receiver count, then for any stray pending pulse
  task automatic wait_cnt(input int e);
    int k;
    for (k = 0; k < 5000 && n0 < e; k++) @(negedge ref_clk);
    if (n0 < e) begin
      // bound used up: count it and close the run
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, n0, e);
      report_and_stop();
    end else begin
      repeat (300) @(negedge ref_clk);
      chk(16'(n0), 16'(e));
    end
  endtask
  initial begin
    void'($urandom(32'hAED6DAA9));
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    rd(ADDR_PLEN, PLEN_RST);
    rd(ADDR_SRC_OUT1, SRC_RST);
    rd(16'h0001, 16'h0000);
    wr(ADDR_SRC_OUT2, SRC_EXTERNAL);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        wr(ADDR_SRC_OUT1, SRC_EXTERNAL);
        wr(ADDR_SRC_OUT2, SRC_COMPARATOR);
        sw = 1'b1;
      end
      cmp_result = 2'($urandom);
      ext_value = 2'($urandom);
      ex = sw ? {cmp_result[1], ext_value[0]}
              : {ext_value[1], cmp_result[0]};
      repeat (2) @(negedge ref_clk);
      chk(16'(dout), 16'(ex));
      rd(ADDR_STATE_OUT1, {15'h0000, ex[0]});
      rd(ADDR_STATE_OUT2, {15'h0000, ex[1]});
    end
    wr(ADDR_SRC_OUT1, 16'h0003);
    repeat (10010) @(negedge ref_clk);
    chk(16'(disp_state), 16'({ex[1], 1'b0}));
    arm = 1'b1;
    wr(ADDR_QSEL_CH1, 16'h0007);
    wr(ADDR_EPP_CH1 + 16'h0001, 16'h0064);
    rd(ADDR_EPP_CH1 + 16'h0001, 16'h0064);
    rd(ADDR_QSEL_CH1, 16'h0007);
    wr(ADDR_PLEN, PLEN_MIN_MS);
    wr(ADDR_SRC_OUT1, SRC_PULSE);
    acc = 0;
    for (int i = 0; i < 6; i++) begin
      base = $urandom_range(150, 20);
      acc += base;
      meas(16'h0007, base);
      meas(16'h0007, -base);
      meas(16'h0003, base);
    end
    wait_cnt(acc / 100);
    chk(16'(h0), 16'(PLEN_MIN_MS * MS));
    chk(16'(l0 >= PLEN_MIN_MS * MS), 16'h0001);
    arm = 1'b0;
    ch = 1'b1;
    wr(ADDR_QSEL_CH2, 16'h0003);
    wr(ADDR_EPP_CH2, 16'hFFFF);
    wr(ADDR_EPP_CH2 + 16'h0001, 16'hFFD8);
    wr(ADDR_SRC_OUT2, SRC_PULSE);
    arm = 1'b1;
    base = n0;
    meas(16'h0003, 500);
    meas(16'h0003, -90);
    wait_cnt(base + 2);
    chk(16'(h0), 16'(PLEN_MIN_MS * MS));
    report_and_stop();
  end
endmodule // tb
